// *** eof_receiver_model.sv ***
`default_nettype none
module eof_receiver_model #(
  parameter bit GENERAL_RX = 1'b0 // 1: plain 8b/10b receiver
) (
  input  wire logic       eof_insert_en, // commas on the lanes
  input  wire logic [7:0] eof_char,      // comma octet seen
  output logic            comma_ok       // receiver keeps alignment
);
  timeunit 1ns;
  timeprecision 1ns;
  // a plain receiver may realign on false commas next to k28.7
  assign comma_ok = !eof_insert_en ||
    (GENERAL_RX ? eof_char != 8'hFC : eof_char == 8'hFC);
endmodule : eof_receiver_model
`default_nettype wire

// *** link_test_pkg.sv ***
`default_nettype none
package link_test_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 8;
  // register offsets
  localparam logic [11:0] ADDR_TEST_SEL = 12'h205;
  localparam logic [11:0] ADDR_DEV_ID   = 12'h206;
  localparam logic [11:0] ADDR_EOF_SEL  = 12'h207;
  // field layout and reset values
  localparam int          TEST_SEL_W    = 5;
  localparam int          EOF_SEL_W     = 2;
  localparam logic [4:0]  TEST_SEL_RST  = 5'h00;
  localparam logic [7:0]  DEV_ID_RST    = 8'h00;
  localparam logic [1:0]  EOF_SEL_RST   = 2'h0;
  localparam logic [7:0]  RDATA_IDLE    = 8'h00;
  // end-of-frame select codes; 0 and reserved 3 both give K28.7
  localparam logic [1:0]  EOF_SEL_K28_1 = 2'h1;
  localparam logic [1:0]  EOF_SEL_K28_5 = 2'h2;
  // test select encodings
  localparam logic [4:0]  TS_NORMAL     = 5'h00;
  localparam logic [4:0]  TS_PRBS7      = 5'h01;
  localparam logic [4:0]  TS_PRBS15     = 5'h02;
  localparam logic [4:0]  TS_PRBS23     = 5'h03;
  localparam logic [4:0]  TS_RAMP       = 5'h04;
  localparam logic [4:0]  TS_TRANSPORT  = 5'h05;
  localparam logic [4:0]  TS_D21_5      = 5'h06;
  localparam logic [4:0]  TS_K28_5      = 5'h07;
  localparam logic [4:0]  TS_ILA        = 5'h08;
  localparam logic [4:0]  TS_RPAT       = 5'h09;
  localparam logic [4:0]  TS_LOW        = 5'h0A;
  localparam logic [4:0]  TS_HIGH       = 5'h0B;
  localparam logic [4:0]  TS_PRBS9      = 5'h0D;
  localparam logic [4:0]  TS_PRBS31     = 5'h0E;
  localparam logic [4:0]  TS_CLOCK      = 5'h0F;
  localparam logic [4:0]  TS_K28_7      = 5'h10;
  // pattern generator kinds
  typedef enum logic [3:0] {
    PAT_NONE, PAT_PRBS, PAT_RAMP, PAT_TRANSPORT, PAT_CHAR, PAT_ILA,
    PAT_RPAT, PAT_LOW, PAT_HIGH, PAT_CLOCK
  } pattern_kind_e;
  // prbs polynomial selects
  typedef enum logic [2:0] {
    PRBS_7, PRBS_9, PRBS_15, PRBS_23, PRBS_31
  } prbs_order_e;
  // 8b/10b test characters (low octet, k flag separate) and clock word
  localparam logic [7:0]  CHAR_K28_7    = 8'hFC;
  localparam logic [7:0]  CHAR_K28_1    = 8'h3C;
  localparam logic [7:0]  CHAR_K28_5    = 8'hBC;
  localparam logic [7:0]  CHAR_D21_5    = 8'hB5;
  localparam logic [15:0] CLOCK_WORD    = 16'h00FF;
endpackage : link_test_pkg
`default_nettype wire

// *** serial_link_test_cfg.sv ***
`default_nettype none
// Contract
// R1 - five-bit test select in low bits; zero means normal data operation
// R2 - select 1, 2, 3 send PRBS7, PRBS15, PRBS23
// R3 - select 4 ramp, 5 transport layer pattern, 6 repeated D21.5
// R4 - select 7 K28.5, 8 repeated ILA, 9 modified RPAT, 16 K28.7
// R5 - select 10 holds lanes static low, 11 static high
// R6 - select 13 PRBS9, 14 PRBS31, 15 clock pattern 0x00FF
// R7 - software never programs 12 or 17 through 31
// R8 - character, ILA, RPAT, K28.7 modes only with 8b/10b link modes
// R9 - software changes these registers only while link enable is clear
// R10 - eight-bit device identifier, reset zero, sent in second ILA multiframe
// R11 - end-of-frame select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved
// R12 - end-of-frame comma inserted opportunistically, only in 8b/10b modes
// R13 - keep K28.7 for standard receivers, K28.1 or K28.5 otherwise
// R14 - software writes reserved upper bits as zero
// R15 - any nonzero test mode replaces payload on every lane until cleared; here reserved codes and 8b/10b-only modes without 8b/10b keep normal data
module serial_link_test_cfg (
  input  wire logic        sys_clk,          // 100 MHz system clock
  input  wire logic        sys_rst,          // synchronous reset, high
  input  wire logic [11:0] reg_addr,         // register address
  input  wire logic [7:0]  reg_wdata,        // register write data
  input  wire logic        reg_wr,           // write strobe
  input  wire logic        reg_rd,           // read strobe
  output logic      [7:0]  reg_rdata,        // read data, cycle after strobe
  input  wire logic        link_is_8b10b,    // link mode uses 8b/10b
  input  wire logic        serial_link_enable, // link enable from control
  output logic      [4:0]  link_test_select, // active test select field
  output logic             test_active,      // payload replaced by pattern
  output logic             test_supported,   // selection valid for mode
  output logic      [3:0]  pattern_kind,     // generator kind to run
  output logic      [2:0]  prbs_order,       // prbs polynomial select
  output logic      [7:0]  pattern_char,     // repeated character octet
  output logic             pattern_char_k,   // repeated character is k
  output logic      [15:0] clock_word,       // clock test word
  output logic             lanes_static,     // lanes held static
  output logic             lanes_level,      // static level when held
  output logic      [7:0]  link_device_identifier, // ila identifier octet
  output logic             eof_insert_en,    // opportunistic comma enable
  output logic      [7:0]  eof_char          // end-of-frame comma octet
);

  // stored register state
  logic [4:0] test_sel_q;
  logic [7:0] dev_id_q;
  logic [1:0] eof_sel_q;
  logic [7:0] rdata_q;

  // address decode
  wire hit_test = (reg_addr == link_test_pkg::ADDR_TEST_SEL);
  wire hit_id   = (reg_addr == link_test_pkg::ADDR_DEV_ID);
  wire hit_eof  = (reg_addr == link_test_pkg::ADDR_EOF_SEL);

  // read mux; reserved bits and unmapped addresses read zero
  wire [7:0] rd_mux =
    hit_test ? {{(link_test_pkg::DATA_W - link_test_pkg::TEST_SEL_W){1'b0}},
                test_sel_q} :
    hit_id   ? dev_id_q :
    hit_eof  ? {{(link_test_pkg::DATA_W - link_test_pkg::EOF_SEL_W){1'b0}},
                eof_sel_q} :
    link_test_pkg::RDATA_IDLE;

  // registers accept writes at any time; software keeps them stable
  // while the link runs, so no lock is applied here  [R9]
  // each field drops the reserved upper data bits, so they store nothing
  // and read back as zero whatever software writes there
  cfg_field_reg #(
    .W    (link_test_pkg::TEST_SEL_W),
    .ADDR (link_test_pkg::ADDR_TEST_SEL),
    .RST  (link_test_pkg::TEST_SEL_RST)
  ) i_test_sel_field (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .field_q   (test_sel_q)                         // [R1] [R14]
  );

  cfg_field_reg #(
    .W    (link_test_pkg::DATA_W),
    .ADDR (link_test_pkg::ADDR_DEV_ID),
    .RST  (link_test_pkg::DEV_ID_RST)
  ) i_dev_id_field (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .field_q   (dev_id_q)                           // [R10]
  );

  cfg_field_reg #(
    .W    (link_test_pkg::EOF_SEL_W),
    .ADDR (link_test_pkg::ADDR_EOF_SEL),
    .RST  (link_test_pkg::EOF_SEL_RST)
  ) i_eof_sel_field (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .field_q   (eof_sel_q)                          // [R11] [R14]
  );

  // read data stands for exactly one cycle after the read strobe and is
  // idle otherwise, so a stale value is never taken for a fresh answer;
  // the price is that software must sample it in that one cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_q <= link_test_pkg::RDATA_IDLE;
    end else begin
      rdata_q <= reg_rd ? rd_mux : link_test_pkg::RDATA_IDLE;
    end
  end

  // decode of the test select into generator controls
  logic [3:0] kind_d;
  logic [2:0] order_d;
  logic [7:0] char_d;
  logic       char_k_d;
  logic       needs_8b10b;
  always_comb begin
    kind_d      = 4'(link_test_pkg::PAT_NONE);
    order_d     = 3'(link_test_pkg::PRBS_7);
    char_d      = 8'h00;
    char_k_d    = 1'b0;
    needs_8b10b = 1'b0;
    unique case (test_sel_q)
      link_test_pkg::TS_NORMAL: kind_d = 4'(link_test_pkg::PAT_NONE); // [R1]
      link_test_pkg::TS_PRBS7: begin
        kind_d  = 4'(link_test_pkg::PAT_PRBS);
        order_d = 3'(link_test_pkg::PRBS_7);               // [R2]
      end
      link_test_pkg::TS_PRBS15: begin
        kind_d  = 4'(link_test_pkg::PAT_PRBS);
        order_d = 3'(link_test_pkg::PRBS_15);              // [R2]
      end
      link_test_pkg::TS_PRBS23: begin
        kind_d  = 4'(link_test_pkg::PAT_PRBS);
        order_d = 3'(link_test_pkg::PRBS_23);              // [R2]
      end
      link_test_pkg::TS_RAMP: kind_d = 4'(link_test_pkg::PAT_RAMP); // [R3]
      link_test_pkg::TS_TRANSPORT: begin
        kind_d = 4'(link_test_pkg::PAT_TRANSPORT);         // [R3]
      end
      link_test_pkg::TS_D21_5: begin
        kind_d      = 4'(link_test_pkg::PAT_CHAR);         // [R3]
        char_d      = link_test_pkg::CHAR_D21_5;
        needs_8b10b = 1'b1;                                // [R8]
      end
      link_test_pkg::TS_K28_5: begin
        kind_d      = 4'(link_test_pkg::PAT_CHAR);         // [R4]
        char_d      = link_test_pkg::CHAR_K28_5;
        char_k_d    = 1'b1;
        needs_8b10b = 1'b1;                                // [R8]
      end
      link_test_pkg::TS_ILA: begin
        kind_d      = 4'(link_test_pkg::PAT_ILA);          // [R4]
        needs_8b10b = 1'b1;                                // [R8]
      end
      link_test_pkg::TS_RPAT: begin
        kind_d      = 4'(link_test_pkg::PAT_RPAT);         // [R4]
        needs_8b10b = 1'b1;                                // [R8]
      end
      link_test_pkg::TS_LOW:  kind_d = 4'(link_test_pkg::PAT_LOW);  // [R5]
      link_test_pkg::TS_HIGH: kind_d = 4'(link_test_pkg::PAT_HIGH); // [R5]
      link_test_pkg::TS_PRBS9: begin
        kind_d  = 4'(link_test_pkg::PAT_PRBS);
        order_d = 3'(link_test_pkg::PRBS_9);               // [R6]
      end
      link_test_pkg::TS_PRBS31: begin
        kind_d  = 4'(link_test_pkg::PAT_PRBS);
        order_d = 3'(link_test_pkg::PRBS_31);              // [R6]
      end
      link_test_pkg::TS_CLOCK: kind_d = 4'(link_test_pkg::PAT_CLOCK); // [R6]
      link_test_pkg::TS_K28_7: begin
        kind_d      = 4'(link_test_pkg::PAT_CHAR);         // [R4]
        char_d      = link_test_pkg::CHAR_K28_7;
        char_k_d    = 1'b1;
        needs_8b10b = 1'b1;                                // [R8]
      end
      // reserved codes fall back to normal data so the lanes never carry
      // an undefined pattern
      default: kind_d = 4'(link_test_pkg::PAT_NONE);       // [R7]
    endcase
  end

  // a character mode under 64b/66b is unsupported: pass normal data
  wire supported_d = !needs_8b10b || link_is_8b10b;         // [R8]
  wire active_d    = (kind_d != 4'(link_test_pkg::PAT_NONE)) && supported_d;

  // end-of-frame comma choice; reserved code 3 keeps the compliant K28.7
  // so a stray write never leaves the lanes with an unknown comma
  wire [7:0] eof_d = (eof_sel_q == link_test_pkg::EOF_SEL_K28_1) ?
                     link_test_pkg::CHAR_K28_1 :
                     (eof_sel_q == link_test_pkg::EOF_SEL_K28_5) ?
                     link_test_pkg::CHAR_K28_5 :
                     link_test_pkg::CHAR_K28_7;             // [R11] [R13]

  // named conditions for the registered lane controls; static_d and level_d look at
  // the decoded kind so a reserved code can never hold the lanes
  wire static_d = active_d &&
                  (kind_d == 4'(link_test_pkg::PAT_LOW) ||
                   kind_d == 4'(link_test_pkg::PAT_HIGH));   // [R5]
  wire level_d  = (kind_d == 4'(link_test_pkg::PAT_HIGH));   // [R5]
  wire insert_d = link_is_8b10b && serial_link_enable;       // [R12]

  // payload replacement; an unsupported or reserved code leaves the
  // lanes on normal data rather than on a pattern the encoder cannot
  // carry
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      test_active    <= 1'b0;
      test_supported <= 1'b1;
      pattern_kind   <= 4'(link_test_pkg::PAT_NONE);
    end else begin
      test_active    <= active_d;                           // [R15]
      test_supported <= supported_d;                        // [R8]
      pattern_kind   <= active_d ? kind_d :
                        4'(link_test_pkg::PAT_NONE);        // [R15]
    end
  end

  // generator settings follow the select even while inactive, so the
  // generators are already set up in the cycle the pattern takes over;
  // consumers must qualify them with test_active
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      prbs_order     <= 3'(link_test_pkg::PRBS_7);
      pattern_char   <= 8'h00;
      pattern_char_k <= 1'b0;
    end else begin
      prbs_order     <= order_d;                            // [R2] [R6]
      pattern_char   <= char_d;                             // [R3] [R4]
      pattern_char_k <= char_k_d;
    end
  end

  // the clock test word is fixed; it sits in a flop only so that every
  // output of the block leaves from a register and sees no logic depth
  // toward the lanes
  always_ff @(posedge sys_clk) begin
    clock_word <= link_test_pkg::CLOCK_WORD;                // [R6]
  end

  // static hold of the serial outputs at one level; the level is only
  // meaningful while lanes_static is high
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      lanes_static <= 1'b0;
      lanes_level  <= 1'b0;
    end else begin
      lanes_static <= static_d;                             // [R5]
      lanes_level  <= level_d;                              // [R5]
    end
  end

  // comma insertion only runs on a live 8b/10b link; under 64b/66b the
  // select is kept but has no effect
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      eof_insert_en <= 1'b0;
      eof_char      <= link_test_pkg::CHAR_K28_7;
    end else begin
      eof_insert_en <= insert_d;                            // [R12]
      eof_char      <= eof_d;                               // [R11]
    end
  end

  // plain register images
  assign reg_rdata              = rdata_q;
  assign link_test_select       = test_sel_q;               // [R1]
  assign link_device_identifier = dev_id_q;                 // [R10]

endmodule : serial_link_test_cfg

// one software field: loads from the low data bits on a write strobe at
// its own offset and holds otherwise; bits above the field are dropped,
// which is what makes reserved bits read back as zero
module cfg_field_reg #(
  parameter int            W    = link_test_pkg::DATA_W,      // width
  parameter logic [11:0]   ADDR = link_test_pkg::ADDR_DEV_ID, // offset
  parameter logic [W-1:0]  RST  = '0                          // reset
) (
  input  wire logic        sys_clk,   // system clock
  input  wire logic        sys_rst,   // synchronous reset, high
  input  wire logic [11:0] reg_addr,  // register address
  input  wire logic [7:0]  reg_wdata, // register write data
  input  wire logic        reg_wr,    // write strobe
  output logic    [W-1:0]  field_q    // stored field value
);

  // this field's own write decode; the read side decodes separately
  // in the parent, so a read never disturbs the stored value
  wire load = reg_wr && (reg_addr == ADDR);

  // reset wins over a write in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      field_q <= RST;
    end else if (load) begin
      field_q <= reg_wdata[W-1:0];
    end
  end

endmodule : cfg_field_reg
`default_nettype wire

// *** serial_link_test_cfg_assertions.sv ***
`default_nettype none
module serial_link_test_cfg_checker (
  input wire logic        sys_clk,                // clock
  input wire logic        sys_rst,                // reset
  input wire logic [11:0] reg_addr,               // address
  input wire logic [7:0]  reg_wdata,              // write data
  input wire logic        reg_wr,                 // write strobe
  input wire logic        reg_rd,                 // read strobe
  input wire logic [7:0]  reg_rdata,              // read data
  input wire logic        link_is_8b10b,          // 8b/10b mode
  input wire logic        serial_link_enable,     // link enable
  input wire logic [4:0]  link_test_select,       // select image
  input wire logic        test_active,            // pattern on
  input wire logic        test_supported,         // mode valid
  input wire logic        lanes_static,           // lanes held
  input wire logic        lanes_level,            // held level
  input wire logic [7:0]  pattern_char,           // char octet
  input wire logic [7:0]  link_device_identifier, // id octet
  input wire logic        eof_insert_en           // comma enable
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // reserved upper bits must read back as zero
  property p_rd_sel; reg_rd && reg_addr == 12'h205
    |=> reg_rdata == {3'h0, link_test_select}; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("select readback");
  property p_wr_sel; reg_wr && reg_addr == 12'h205
    |=> link_test_select == $past(reg_wdata[4:0]); endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("select write");
  property p_did; reg_wr && reg_addr == 12'h206
    |=> link_device_identifier == $past(reg_wdata); endproperty
  a_did: assert property (p_did) else $error("identifier write");
  property p_normal; link_test_select == 5'h00
    |=> !test_active && !lanes_static; endproperty
  a_normal: assert property (p_normal) else $error("normal mode");
  property p_static; link_test_select inside {5'h0A, 5'h0B}
    |=> lanes_static && lanes_level == $past(link_test_select[0]); endproperty
  a_static: assert property (p_static) else $error("static lanes");
  property p_rsvd; link_test_select == 5'h0C || link_test_select > 5'h10
    |=> !test_active; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved code");
  property p_k287; link_test_select == 5'h10 && link_is_8b10b
    |=> test_active && pattern_char == 8'hFC; endproperty
  a_k287: assert property (p_k287) else $error("k28.7 mode");
  property p_unsup; link_test_select == 5'h06 && !link_is_8b10b
    |=> !test_active && !test_supported; endproperty
  a_unsup: assert property (p_unsup) else $error("char mode");
  // first edge after reset still sees reset-time inputs, so skip it
  property p_eof; !$past(sys_rst) |-> eof_insert_en ==
    $past(link_is_8b10b && serial_link_enable); endproperty
  a_eof: assert property (p_eof) else $error("comma enable");
endmodule : serial_link_test_cfg_checker
bind serial_link_test_cfg serial_link_test_cfg_checker
  i_serial_link_test_cfg_checker (.sys_clk, .sys_rst, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_is_8b10b,
  .serial_link_enable, .link_test_select, .test_active, .test_supported,
  .lanes_static, .lanes_level, .pattern_char, .link_device_identifier,
  .eof_insert_en);
`default_nettype wire

// *** serial_link_test_cfg_tb.sv ***
`default_nettype none
module serial_link_test_cfg_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, xc, comma_ok, ea;
  logic link_is_8b10b = 0, serial_link_enable = 0, pattern_char_k;
  logic test_active, test_supported, lanes_static, lanes_level;
  logic eof_insert_en;
  logic [11:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, pattern_char, eof_char;
  logic [7:0]  link_device_identifier;
  logic [4:0]  link_test_select;
  logic [3:0]  pattern_kind;
  logic [2:0]  prbs_order;
  logic [15:0] clock_word;
  logic [7:0]  ids[$];
  int          failures = 0, total_checks = 0, e;
  always #5 sys_clk = ~sys_clk;
  serial_link_test_cfg i_serial_link_test_cfg (.sys_clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_is_8b10b,
    .serial_link_enable, .link_test_select, .test_active, .test_supported,
    .pattern_kind, .prbs_order, .pattern_char, .pattern_char_k, .clock_word,
    .lanes_static, .lanes_level, .link_device_identifier, .eof_insert_en,
    .eof_char);
  eof_receiver_model i_eof_receiver_model (.eof_insert_en, .eof_char,
    .comma_ok);
  task automatic check(input string n, input logic [15:0] s, x);
    total_checks++;
    if (s !== x) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", reg_rdata, x);
  endtask : rd
  // pattern generator expected for an accepted select code
  function automatic logic [3:0] kind_of(input int s);
    case (s)
      1, 2, 3, 13, 14: return link_test_pkg::PAT_PRBS;
      4: return link_test_pkg::PAT_RAMP;
      5: return link_test_pkg::PAT_TRANSPORT;
      6, 7, 16: return link_test_pkg::PAT_CHAR;
      8: return link_test_pkg::PAT_ILA;
      9: return link_test_pkg::PAT_RPAT;
      10: return link_test_pkg::PAT_LOW;
      11: return link_test_pkg::PAT_HIGH;
      15: return link_test_pkg::PAT_CLOCK;
      default: return link_test_pkg::PAT_NONE;
    endcase
  endfunction : kind_of
  task automatic wrap_up();
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // every select code in both link encodings, link disabled during that sweep
  initial begin
    void'($urandom(26));
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(12'h205, 8'h00);
    rd(12'h206, 8'h00);
    rd(12'h207, 8'h00);
    check("eof_char", eof_char, 8'hFC);
    check("test_supported", test_supported, 1'b1);
    for (int m = 0; m < 64; m++) begin
      e = m % 32;
      xc = e inside {[6:9], 16};
      ea = kind_of(e) != 0 && !(xc && !m[5]);
      @(posedge sys_clk);
      link_is_8b10b <= m[5];
      wr(12'h205, 8'(e));
      repeat (2) @(posedge sys_clk);
      #1 check("test_active", test_active, ea);
      check("pattern_kind", pattern_kind, ea ? kind_of(e) : 4'h0);
      check("test_supported", test_supported, !(xc && !m[5]));
      check("lanes_static", lanes_static, e inside {10, 11});
      check("lanes_level", lanes_level, e == 11);
      if (m[5] && xc && e != 8 && e != 9) begin
        check("pattern_char", pattern_char,
              e == 6 ? 8'hB5 : e == 7 ? 8'hBC : 8'hFC);
        check("pattern_char_k", pattern_char_k, e != 6);
      end
      if (e == 15) check("clock_word", clock_word, 16'h00FF);
      if (e inside {1, 2, 3, 13, 14})
        check("prbs_order", prbs_order,
              e == 1 ? 0 : e == 13 ? 1 : e == 2 ? 2 : e == 3 ? 3 : 4);
    end
    rd(12'h208, 8'h00);
    repeat (4) begin
      ids.push_back(8'($urandom));
      wr(12'h206, ids[0]);
      rd(12'h206, ids[0]);
      check("link_device_identifier", link_device_identifier,
            ids.pop_front());
    end
    for (int c = 0; c < 4; c++) begin
      wr(12'h207, 8'(c));
      @(posedge sys_clk);
      link_is_8b10b <= c != 1;
      serial_link_enable <= c != 2;
      repeat (2) @(posedge sys_clk);
      #1 check("eof_char", eof_char,
               c == 1 ? 8'h3C : c == 2 ? 8'hBC : 8'hFC);
      check("eof_insert_en", eof_insert_en, c == 0 || c == 3);
      check("comma_ok", comma_ok, 1'b1);
      @(posedge sys_clk);
      serial_link_enable <= 1'b0;
    end
    wrap_up();
  end
endmodule : serial_link_test_cfg_tb
`default_nettype wire
